// ==== hdl/css_pkg.sv ====
/*
 * Constants for the conditional-sign summation slice: instruction field
 * positions, instruction codes, effect bits, reset values and timing.
 * Assumes a 32-bit datapath and a single 50 MHz clock.
 */
package css_pkg;
    localparam int          CSS_DW          = 32;
    localparam int          CSS_AW          = 9;
    localparam int          CSS_IW          = 32;
    // instruction field positions
    localparam int          CSS_OP_LSB      = 26;
    localparam int          CSS_EFF_Z       = 25;
    localparam int          CSS_EFF_C       = 24;
    localparam int          CSS_EFF_R       = 23;
    localparam int          CSS_EFF_I       = 22;
    localparam int          CSS_CON_LSB     = 18;
    localparam int          CSS_DST_LSB     = 9;
    localparam int          CSS_SRC_LSB     = 0;
    // instruction codes
    localparam logic [5:0]  CSS_OP_NEG_UNLESS_SPILL = 6'h25;
    localparam logic [5:0]  CSS_OP_NEG_WHEN_NIL     = 6'h26;
    localparam logic [5:0]  CSS_OP_NEG_UNLESS_NIL   = 6'h27;
    localparam logic [3:0]  CSS_CON_ALWAYS  = 4'hF;
    // cycles per instruction and stage indices
    localparam logic [1:0]  CSS_LAST_STAGE  = 2'h3;
    localparam logic [1:0]  CSS_STAGE_RST   = 2'h0;
    localparam logic        CSS_FLAG_RST    = 1'b0;
    localparam logic [31:0] CSS_WORD_RST    = 32'h0000_0000;

    typedef enum logic [1:0] {
        CSS_VAR_UNLESS_SPILL,
        CSS_VAR_UNLESS_NIL,
        CSS_VAR_WHEN_NIL
    } css_var_e;
endpackage

// ==== hdl/css_sum_if.sv ====
/*
 * Carrier between the sequencer and the summing core of the slice.
 * Assumes both ends on the same clock.
 */
`timescale 1ns/1ns
interface css_sum_if;
    logic [31:0] dest_operand;
    logic [31:0] src_operand;
    logic        negate;
    logic [31:0] sum;
    logic        nil;
    logic        ovf;
    modport seq  (output dest_operand, output src_operand, output negate, input sum, input nil, input ovf);
    modport core (input dest_operand, input src_operand, input negate, output sum, output nil, output ovf);
endinterface

// ==== hdl/css_sum_core.sv ====
/*
 * Registered conditional-sign adder: dest +/- src with zero and signed
 * overflow detection. Assumes operands held stable for one clock.
 */
`timescale 1ns/1ns
module css_sum_core (
    input  wire logic clk,
    input  wire logic rst_b,
    css_sum_if.core   sif
);
    import css_pkg::*;

    logic [31:0] sum_r, sum_nxt;
    logic        nil_r, nil_nxt;
    logic        ovf_r, ovf_nxt;
    logic [31:0] addend;

    always_comb begin
        addend  = sif.negate ? (~sif.src_operand + 32'h0000_0001) : sif.src_operand;
        sum_nxt = sif.dest_operand + addend;                     // wraps mod 2^32 [RULE10]
        nil_nxt = (sum_nxt == CSS_WORD_RST);
        // overflow from true operand signs; negating the minimum word flips sign too
        ovf_nxt = (sif.dest_operand[31] == (sif.src_operand[31] ^ sif.negate))
                  && (sum_nxt[31] != sif.dest_operand[31])
                  && !(sif.negate && sif.src_operand == 32'h8000_0000) ||
                  (sif.negate && sif.src_operand == 32'h8000_0000 && !sif.dest_operand[31]); // [RULE10]
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sum_r <= CSS_WORD_RST;
            nil_r <= CSS_FLAG_RST;
            ovf_r <= CSS_FLAG_RST;
        end else begin
            sum_r <= sum_nxt;
            nil_r <= nil_nxt;
            ovf_r <= ovf_nxt;
        end
    end

    assign sif.sum = sum_r;
    assign sif.nil = nil_r;
    assign sif.ovf = ovf_r;

    chk_sum_value: assert property (@(posedge clk) disable iff (!rst_b) // [RULE10]
        1'b1 |=> sum_r == $past(sif.dest_operand) + ($past(sif.negate) ? -$past(sif.src_operand)
                                                                     : $past(sif.src_operand)))
        else $error("sum mismatch");
endmodule

// ==== hdl/css_alu.sv ====
/*
 * Conditional-sign summation slice of a processor core.
 * Assumes the decoder holds instr while busy, the register file answers a
 * read in the same cycle, and the flag state is kept here.
 */
// Overview of operation
// RULE1: spill-conditioned: spill 1 adds, 0 subtracts
// RULE2: nil-conditioned inverse: nil 1 adds, 0 subtracts
// RULE3: nil-conditioned direct: nil 1 subtracts, 0 adds
// RULE4: nil update sets flag on zero sum
// RULE5: spill update sets flag on signed overflow
// RULE6: write back unless no_writeback; flags only then (code updates flags from their effect bits even with no_writeback)
// RULE7: source from register or 9-bit immediate
// RULE8: code 100101, effects 001i, always, 4 clocks
// RULE9: destination field addresses operand and result
// RULE10: 32-bit wrapping sum, signed overflow detect
// RULE11: zero variants distinct codes, same layout, timing
`timescale 1ns/1ns
module css_alu (
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    input  wire logic                         issue,
    input  wire logic [css_pkg::CSS_IW-1:0]   instr,
    output logic                              busy,
    output logic                              done,
    output logic                              illegal,
    output logic      [css_pkg::CSS_AW-1:0]   rd_addr_a,
    output logic      [css_pkg::CSS_AW-1:0]   rd_addr_b,
    input  wire logic [css_pkg::CSS_DW-1:0]   rd_data_a,
    input  wire logic [css_pkg::CSS_DW-1:0]   rd_data_b,
    output logic                              wr_en,
    output logic      [css_pkg::CSS_AW-1:0]   wr_addr,
    output logic      [css_pkg::CSS_DW-1:0]   wr_data,
    output logic                              nil_flag,
    output logic                              spill_flag
);
    import css_pkg::*;

    typedef enum logic [1:0] {CSS_IDLE, CSS_FETCH, CSS_ADD, CSS_WRITE} css_state_e;

    css_state_e        state_r, state_nxt;
    logic [31:0]       ins_r, ins_nxt;
    logic [CSS_AW-1:0] rd_a_r, rd_a_nxt, rd_b_r, rd_b_nxt, wa_r, wa_nxt;
    logic              busy_r, busy_nxt, done_r, done_nxt, ill_r, ill_nxt;
    logic              we_r, we_nxt, nil_r, nil_nxt, spill_r, spill_nxt;
    logic [31:0]       wd_r, wd_nxt;
    logic [31:0]       dop_r, dop_nxt, sop_r, sop_nxt;
    logic              neg_r, neg_nxt;
    logic              op_ok;
    css_var_e          var_sel;
    // check aid only: nothing in the datapath reads it
    logic [32:0]       ref_sum;

    css_sum_if sif ();
    css_sum_core u_core (
        .clk   (clk),
        .rst_b (rst_b),
        .sif   (sif)
    );
    assign sif.dest_operand = dop_r;
    assign sif.src_operand  = sop_r;
    assign sif.negate       = neg_r;

    // decode of the three variants; same field layout for all [RULE11]
    always_comb begin
        op_ok   = 1'b1;
        var_sel = CSS_VAR_UNLESS_SPILL;
        case (instr[CSS_OP_LSB +: 6])
            CSS_OP_NEG_UNLESS_SPILL: var_sel = CSS_VAR_UNLESS_SPILL; // [RULE8]
            CSS_OP_NEG_UNLESS_NIL:   var_sel = CSS_VAR_UNLESS_NIL;   // [RULE11]
            CSS_OP_NEG_WHEN_NIL:     var_sel = CSS_VAR_WHEN_NIL;     // [RULE11]
            default:                 op_ok   = 1'b0;
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        ins_nxt   = ins_r;
        rd_a_nxt  = rd_a_r;
        rd_b_nxt  = rd_b_r;
        wa_nxt    = wa_r;
        busy_nxt  = busy_r;
        done_nxt  = 1'b0;
        ill_nxt   = 1'b0;
        we_nxt    = 1'b0;
        wd_nxt    = wd_r;
        nil_nxt   = nil_r;
        spill_nxt = spill_r;
        dop_nxt   = dop_r;
        sop_nxt   = sop_r;
        neg_nxt   = neg_r;
        case (state_r)
            CSS_IDLE: begin
                if (issue) begin
                    if (op_ok) begin
                        ins_nxt   = instr;
                        rd_a_nxt  = instr[CSS_DST_LSB +: CSS_AW];          // [RULE9]
                        rd_b_nxt  = instr[CSS_SRC_LSB +: CSS_AW];
                        busy_nxt  = 1'b1;
                        state_nxt = CSS_FETCH;
                        case (var_sel)
                            CSS_VAR_UNLESS_SPILL: neg_nxt = !spill_r;      // [RULE1]
                            CSS_VAR_UNLESS_NIL:   neg_nxt = !nil_r;        // [RULE2]
                            CSS_VAR_WHEN_NIL:     neg_nxt = nil_r;         // [RULE3]
                            default:              neg_nxt = 1'b0;
                        endcase
                    end else begin
                        ill_nxt = 1'b1;
                    end
                end
            end
            CSS_FETCH: begin
                dop_nxt   = rd_data_a;
                // immediate is the zero-extended 9-bit source field
                sop_nxt   = ins_r[CSS_EFF_I] ? {23'h000000, ins_r[CSS_SRC_LSB +: CSS_AW]} : rd_data_b; // [RULE7]
                state_nxt = CSS_ADD;
            end
            CSS_ADD: state_nxt = CSS_WRITE;
            CSS_WRITE: begin
                if (ins_r[CSS_EFF_Z]) nil_nxt = sif.nil;               // [RULE4]
                if (ins_r[CSS_EFF_C]) spill_nxt = sif.ovf;             // [RULE5]
                we_nxt    = ins_r[CSS_EFF_R];                          // [RULE6]
                wa_nxt    = ins_r[CSS_DST_LSB +: CSS_AW];              // [RULE9]
                wd_nxt    = sif.sum;
                done_nxt  = 1'b1;
                busy_nxt  = 1'b0;
                state_nxt = CSS_IDLE;                                  // 4 clocks [RULE8]
            end
            default: state_nxt = CSS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= CSS_IDLE;
            ins_r   <= CSS_WORD_RST;
            rd_a_r  <= '0;
            rd_b_r  <= '0;
            wa_r    <= '0;
            busy_r  <= CSS_FLAG_RST;
            done_r  <= CSS_FLAG_RST;
            ill_r   <= CSS_FLAG_RST;
            we_r    <= CSS_FLAG_RST;
            wd_r    <= CSS_WORD_RST;
            nil_r   <= CSS_FLAG_RST;
            spill_r <= CSS_FLAG_RST;
            dop_r   <= CSS_WORD_RST;
            sop_r   <= CSS_WORD_RST;
            neg_r   <= CSS_FLAG_RST;
        end else begin
            state_r <= state_nxt;
            ins_r   <= ins_nxt;
            rd_a_r  <= rd_a_nxt;
            rd_b_r  <= rd_b_nxt;
            wa_r    <= wa_nxt;
            busy_r  <= busy_nxt;
            done_r  <= done_nxt;
            ill_r   <= ill_nxt;
            we_r    <= we_nxt;
            wd_r    <= wd_nxt;
            nil_r   <= nil_nxt;
            spill_r <= spill_nxt;
            dop_r   <= dop_nxt;
            sop_r   <= sop_nxt;
            neg_r   <= neg_nxt;
        end
    end

    assign busy       = busy_r;
    assign done       = done_r;
    assign illegal    = ill_r;
    assign rd_addr_a  = rd_a_r;
    assign rd_addr_b  = rd_b_r;
    assign wr_en      = we_r;
    assign wr_addr    = wa_r;
    assign wr_data    = wd_r;
    assign nil_flag   = nil_r;
    assign spill_flag = spill_r;

    // one bit wider than the datapath so overflow is read off the top two bits,
    // independent of the core's own overflow terms; operands hold until the next fetch
    assign ref_sum = neg_r ? ({dop_r[31], dop_r} - {sop_r[31], sop_r})
                           : ({dop_r[31], dop_r} + {sop_r[31], sop_r});

    chk_four_clock_done: assert property (@(posedge clk) disable iff (!rst_b) // [RULE8]
        (state_r == CSS_IDLE && issue && op_ok) |-> ##4 done_r)
        else $error("instruction did not finish in 4 clocks");
    chk_spill_sign_sel: assert property (@(posedge clk) disable iff (!rst_b) // [RULE1]
        (state_r == CSS_IDLE && issue && instr[CSS_OP_LSB +: 6] == CSS_OP_NEG_UNLESS_SPILL) |=> neg_r == !$past(spill_r))
        else $error("spill-conditioned sign wrong");
    chk_nil_inv_sel: assert property (@(posedge clk) disable iff (!rst_b) // [RULE2]
        (state_r == CSS_IDLE && issue && instr[CSS_OP_LSB +: 6] == CSS_OP_NEG_UNLESS_NIL) |=> neg_r == !$past(nil_r))
        else $error("nil inverse sign wrong");
    chk_nil_dir_sel: assert property (@(posedge clk) disable iff (!rst_b) // [RULE3]
        (state_r == CSS_IDLE && issue && instr[CSS_OP_LSB +: 6] == CSS_OP_NEG_WHEN_NIL) |=> neg_r == $past(nil_r))
        else $error("nil direct sign wrong");
    chk_nil_update: assert property (@(posedge clk) disable iff (!rst_b) // [RULE4]
        done_r |-> nil_r == ($past(ins_r[CSS_EFF_Z]) ? (wd_r == 32'h0000_0000) : $past(nil_r)))
        else $error("nil flag wrong");
    chk_spill_update: assert property (@(posedge clk) disable iff (!rst_b) // [RULE5]
        (done_r && !$past(ins_r[CSS_EFF_C])) |-> spill_r == $past(spill_r))
        else $error("spill flag changed without request");
    chk_spill_value: assert property (@(posedge clk) disable iff (!rst_b) // [RULE5]
        (done_r && ins_r[CSS_EFF_C]) |-> spill_r == (ref_sum[32] ^ ref_sum[31]))
        else $error("spill flag differs from signed overflow");
    chk_writeback_gate: assert property (@(posedge clk) disable iff (!rst_b) // [RULE6]
        wr_en |-> done_r && $past(ins_r[CSS_EFF_R]))
        else $error("write-back despite no_writeback");
    chk_write_value: assert property (@(posedge clk) disable iff (!rst_b) // [RULE10]
        wr_en |-> wr_data == ref_sum[31:0])
        else $error("written sum differs from wrapped sum");
    chk_dest_addr: assert property (@(posedge clk) disable iff (!rst_b) // [RULE9]
        wr_en |-> wr_addr == rd_addr_a)
        else $error("write address differs from operand address");
    chk_imm_source: assert property (@(posedge clk) disable iff (!rst_b) // [RULE7]
        (state_r == CSS_FETCH && ins_r[CSS_EFF_I]) |=> sop_r == {23'h000000, $past(ins_r[8:0])})
        else $error("immediate source wrong");
    // an unknown code must pulse and leave the sequencer idle
    chk_illegal_pulse: assert property (@(posedge clk) disable iff (!rst_b) // [RULE8]
        (state_r == CSS_IDLE && issue && !op_ok) |=> ill_r && state_r == CSS_IDLE)
        else $error("unknown code not refused");
    chk_busy_refusal: assert property (@(posedge clk) disable iff (!rst_b) // [RULE8]
        (busy_r && issue) |=> ins_r == $past(ins_r))
        else $error("instruction taken while busy");
endmodule

// ==== verification/css_reg_model.sv ====
/*
 * Behavioural register file standing at the far side of the slice.
 * Assumes the bench preloads mem by hierarchical assignment before reset ends.
 */
`timescale 1ns/1ns
module css_reg_model (
    input  wire logic                         clk,
    input  wire logic [css_pkg::CSS_AW-1:0]   rd_addr_a,
    input  wire logic [css_pkg::CSS_AW-1:0]   rd_addr_b,
    output logic      [css_pkg::CSS_DW-1:0]   rd_data_a,
    output logic      [css_pkg::CSS_DW-1:0]   rd_data_b,
    input  wire logic                         wr_en,
    input  wire logic [css_pkg::CSS_AW-1:0]   wr_addr,
    input  wire logic [css_pkg::CSS_DW-1:0]   wr_data
);
    import css_pkg::*;
    logic [CSS_DW-1:0] mem [0:511];
    // same-cycle read, as the slice samples one cycle after acceptance
    assign rd_data_a = mem[rd_addr_a];
    assign rd_data_b = mem[rd_addr_b];
    always @(posedge clk) begin
        if (wr_en === 1'b1) begin
            mem[wr_addr] <= wr_data;
        end
    end
endmodule

// ==== verification/tb_css_alu.sv ====
/*
 * Self-checking bench for the conditional-sign summation slice.
 * Assumes css_reg_model as register file; results compared from a queue.
 */
`timescale 1ns/1ns
module tb_css_alu;
    import css_pkg::*;
    typedef struct packed {
        logic        we;
        logic [8:0]  wa;
        logic [31:0] wd;
        logic        nz;
        logic        sp;
    } css_exp_s;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        issue = 1'b0;
    logic [31:0] instr = 32'h0000_0000;
    logic        busy, done, illegal, wr_en, nil_flag, spill_flag;
    logic [8:0]  rd_addr_a, rd_addr_b, wr_addr;
    logic [31:0] rd_data_a, rd_data_b, wr_data;
    logic [31:0] regs [0:511];
    logic        m_nil = 1'b0;
    logic        m_spill = 1'b0;
    css_exp_s    exp_q [$];
    css_exp_s    e;
    int          err_total = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [31:0] corner [5] = '{32'h0000_0000, 32'h0000_0001, 32'hFFFF_FFFF, 32'h8000_0000, 32'h7FFF_FFFF};
    logic [5:0]  codes [3] = '{CSS_OP_NEG_UNLESS_SPILL, CSS_OP_NEG_UNLESS_NIL, CSS_OP_NEG_WHEN_NIL};

    always #10 clk = ~clk;

    css_alu u_css_alu (.clk(clk), .rst_b(rst_b), .issue(issue), .instr(instr), .busy(busy), .done(done),
        .illegal(illegal), .rd_addr_a(rd_addr_a), .rd_addr_b(rd_addr_b), .rd_data_a(rd_data_a),
        .rd_data_b(rd_data_b), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .nil_flag(nil_flag), .spill_flag(spill_flag));
    css_reg_model u_css_reg_model (.clk(clk), .rd_addr_a(rd_addr_a), .rd_addr_b(rd_addr_b),
        .rd_data_a(rd_data_a), .rd_data_b(rd_data_b), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        samples_checked++;
        if (seen !== expv) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // one instruction; issue stays high through the first busy cycle to probe refusal
    task automatic run(input logic [5:0] code, input logic [3:0] eff, input logic [8:0] dst, input logic [8:0] src);
        logic [31:0] d, s;
        logic [32:0] ext;
        logic        neg;
        int          n;
        d = regs[dst];
        s = eff[0] ? {23'h0, src} : regs[src];
        neg = (code == CSS_OP_NEG_UNLESS_SPILL) ? !m_spill : (code == CSS_OP_NEG_UNLESS_NIL) ? !m_nil : m_nil;
        ext = neg ? {d[31], d} - {s[31], s} : {d[31], d} + {s[31], s};
        if (eff[3]) m_nil = (ext[31:0] == 32'h0);
        if (eff[2]) m_spill = ext[32] ^ ext[31];
        if (eff[1]) regs[dst] = ext[31:0];
        exp_q.push_back('{eff[1], dst, ext[31:0], m_nil, m_spill});
        instr = {code, eff, CSS_CON_ALWAYS, dst, src};
        issue = 1'b1;
        @(negedge clk);
        check(32'(rd_addr_a), 32'(dst));
        check(32'(rd_addr_b), 32'(src));
        @(negedge clk);
        issue = 1'b0;
        n = 2;
        while (done !== 1'b1 && n < 12) begin
            @(negedge clk);
            n++;
        end
        check(32'(n), 32'h0000_0004);
    endtask

    // unknown code: one-cycle refusal pulse and no completion
    task automatic bad(input logic [5:0] code);
        instr = {code, 4'hE, CSS_CON_ALWAYS, 9'h001, 9'h002};
        issue = 1'b1;
        @(negedge clk);
        issue = 1'b0;
        check(32'(illegal), 32'h1);
        @(negedge clk);
        check(32'({illegal, busy, done}), 32'h0);
    endtask

    always @(negedge clk) begin
        if (done === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("Error at %0t: completion with nothing pending", $time);
            end else begin
                e = exp_q.pop_front();
                check(32'(wr_en), 32'(e.we));
                if (e.we) check(32'(wr_addr), 32'(e.wa));
                if (e.we) check(wr_data, e.wd);
                check(32'(nil_flag), 32'(e.nz));
                check(32'(spill_flag), 32'(e.sp));
            end
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            err_total++;
            finish_test();
        end
    end

    initial begin
        void'($urandom(90));
        // corner-heavy operands so zero sums and overflows both occur often
        for (int i = 0; i < 512; i++) begin
            regs[i] = i[0] ? $urandom() : corner[$urandom_range(4)];
            u_css_reg_model.mem[i] = regs[i];
        end
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        for (int i = 0; i < 300; i++)
            run(codes[$urandom_range(2)], 4'($urandom()), 9'($urandom()), 9'($urandom()));
        $display("test mixed sequence ended");
        for (int c = 0; c < 64; c++)
            if (c < 32'(CSS_OP_NEG_UNLESS_SPILL) || c > 32'(CSS_OP_NEG_UNLESS_NIL)) bad(6'(c));
        $display("test unknown codes ended");
        for (int i = 0; i < 100; i++)
            run(codes[i % 3], 4'($urandom()), 9'($urandom_range(7)), 9'($urandom_range(7)));
        repeat (2) @(negedge clk);
        check(32'(exp_q.size()), 32'h0);
        $display("test shared registers ended");
        finish_test();
    end
endmodule
